//--- verilog/multi_queue_cell_fifo_pkg.sv
/*
 * Constants for the three-queue cell FIFO.
 * Assumes one clock domain for writer, reader and programmer.
 */
package multi_queue_cell_fifo_pkg;

    localparam int NUM_QUEUES      = 3;
    localparam int DATA_W          = 18;
    localparam int BYTE_W          = 9;
    localparam int TOTAL_BLOCKS    = 16;
    localparam int BLOCK_WORDS_DEF = 256;

    // port control field positions
    localparam int PORT_IN_BYTE     = 0;
    localparam int PORT_IN_BIG      = 1;
    localparam int PORT_IN_STUFF    = 2;
    localparam int PORT_OUT_BYTE    = 3;
    localparam int PORT_OUT_DESTUFF = 4;

    // configuration reset values and limits
    localparam logic [4:0] PORT_RST = 5'h00;
    localparam logic [4:0] QL1_RST  = 5'h08;
    localparam logic [3:0] QL2_RST  = 4'h6;
    localparam logic [4:0] QL1_MAX  = 5'h10;
    localparam logic [3:0] QL2_MAX  = 4'hf;
    localparam logic [5:0] CELL_WORD_COUNT_RST = 6'h1b;
    localparam logic [5:0] CELL_WORD_COUNT_MIN = 6'h0a;
    localparam logic [5:0] CELL_WORD_COUNT_MAX = 6'h20;

    // programming sequence positions
    localparam logic [3:0] PROG_IDX_PORT  = 4'h0;
    localparam logic [3:0] PROG_IDX_QL1   = 4'h1;
    localparam logic [3:0] PROG_IDX_QL2   = 4'h2;
    localparam logic [3:0] PROG_IDX_CELL_WORD_COUNT  = 4'h3;
    localparam logic [3:0] PROG_REG_COUNT = 4'ha;
    localparam logic [3:0] PROG_IDX_LAST  = 4'h9;

    // queue selection codes
    localparam logic [1:0] SEL_QUEUE_TWO   = 2'h2;
    localparam logic [1:0] SEL_QUEUE_THREE = 2'h3;

    // output buffer depth
    localparam logic [1:0] OBUF_FULL = 2'h2;

endpackage

//--- verilog/multi_queue_cell_fifo.sv
/*
 * Three-queue cell FIFO data path with flip-flop storage, a sequential
 * configuration port, cell alignment and abort on the write side, queue
 * selection, byte output and a two-entry output buffer on the read side.
 * Assumes writer, reader and programmer all run on clk; no input here
 * crosses a clock domain.
 */
// Behaviour
// R1: port bit 0 selects word or byte input
// R2: big order puts first byte high
// R3: stuffing ends cell on first last-word byte
// R4: port bit 3 selects word or byte output
// R5: destuffing skips last byte of a cell
// R6: queue lengths count BLOCK_WORDS-word blocks, 256 by default
// R7: cell size gives words per cell
// R8: granted writes go to enabled non-full queues
// R9: writer marks first write of each cell
// R10: alignment mismatch blocks write, drops misalign flag
// R11: completed cell updates flags and abort marker
// R12: discard rewinds write pointer, stores nothing
// R13: read needs enable and cell available
// R14: select 00/01 queue one, 10 two, 11 three
// R15: byte output swaps halves on second read
// R16: flags update at end of cell read
// R17: cell start flags a cell's first word
// R18: switching queues reads or shows held word
// R19: reader switches queues whenever queue select changes, mid-cell too
// R20: cell available rises second edge after fill
// R21: cell available drops on last cell read
// R22: full flag from max cells, two-edge release
// R23: reset held long enough clears flags
// R24: bus request revokes input grant after two edges
module multi_queue_cell_fifo
    import multi_queue_cell_fifo_pkg::*;
#(
    parameter int BLOCK_WORDS = BLOCK_WORDS_DEF
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  sys_rst,
    // write side
    input  wire logic [DATA_W-1:0]     din,
    input  wire logic [NUM_QUEUES-1:0] queue_write_enable,
    input  wire logic                  in_cell_start,
    input  wire logic                  cell_discard_n,
    output logic      [NUM_QUEUES-1:0] queue_full_n,
    output logic                       cell_misalign_n,
    output logic                       input_port_granted,
    // configuration port
    input  wire logic                  config_bus_request_n,
    input  wire logic                  prog_write,
    input  wire logic [7:0]            prog_wdata,
    input  wire logic                  prog_read,
    output logic      [7:0]            prog_rdata,
    // read side
    input  wire logic [1:0]            queue_select,
    input  wire logic                  out_read_enable,
    output logic      [NUM_QUEUES-1:0] cell_available,
    output logic      [DATA_W-1:0]     q_data,
    output logic                       out_cell_start,
    output logic                       out_word_valid,
    input  wire logic                  out_word_ready
);

    localparam int MEM_WORDS = TOTAL_BLOCKS * BLOCK_WORDS;
    localparam int AW        = $clog2(MEM_WORDS);
    localparam int BSH       = $clog2(BLOCK_WORDS);

    generate
        if (BLOCK_WORDS < 32 || (1 << BSH) != BLOCK_WORDS) begin : g_chk
            $error("BLOCK_WORDS must be a power of two, at least 32");
        end
    endgenerate

    typedef struct packed {
        logic [MEM_WORDS-1:0][DATA_W-1:0]  mem;
        logic [NUM_QUEUES-1:0][AW-1:0]     wr_ptr;
        logic [NUM_QUEUES-1:0][AW-1:0]     abort_ptr;
        logic [NUM_QUEUES-1:0][AW-1:0]     rd_ptr;
        logic [NUM_QUEUES-1:0][5:0]        wr_idx;
        logic [NUM_QUEUES-1:0][5:0]        rd_idx;
        logic [NUM_QUEUES-1:0]             wr_phase;
        logic [NUM_QUEUES-1:0]             rd_phase;
        logic [NUM_QUEUES-1:0][BYTE_W-1:0] wr_byte;
        logic [NUM_QUEUES-1:0][AW:0]       cells;
        logic [NUM_QUEUES-1:0][DATA_W-1:0] hold;
        logic [NUM_QUEUES-1:0]             hold_sof;
        logic [NUM_QUEUES-1:0][1:0]        ca_pipe;
        logic [NUM_QUEUES-1:0][1:0]        fr_pipe;
        logic [NUM_QUEUES-1:0]             cell_available;
        logic [NUM_QUEUES-1:0]             queue_full_n;
        logic                              misalign_n;
        logic [1:0]                        grant;
        logic [4:0]                        port_ctl;
        logic [4:0]                        ql1;
        logic [3:0]                        ql2;
        logic [5:0]                        cell_word_count;
        logic [3:0]                        prog_widx;
        logic [3:0]                        prog_ridx;
        logic [7:0]                        prog_rdata;
        logic [1:0]                        sel_q;
        logic [1:0][DATA_W:0]              obuf;
        logic [1:0]                        obuf_cnt;
        logic                              out_valid;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [3:0]                    ql3_len;
    logic [NUM_QUEUES-1:0][AW:0]   depth;
    logic [NUM_QUEUES-1:0][AW:0]   max_cells;
    logic [NUM_QUEUES-1:0][AW-1:0] base;
    logic [5:0]                    last_idx;
    logic [NUM_QUEUES-1:0]         wr_sof;
    logic [NUM_QUEUES-1:0]         attempt;
    logic [NUM_QUEUES-1:0]         cell_in;
    logic [NUM_QUEUES-1:0]         cell_out;
    logic [NUM_QUEUES-1:0][AW:0]   cells_after;
    logic                          mis;
    logic [AW-1:0]                 waddr;
    logic [AW-1:0]                 wr_next;
    logic [DATA_W-1:0]             word;
    logic                          store;
    logic [1:0]                    sel;
    logic [AW-1:0]                 raddr;
    logic [AW-1:0]                 rd_next;
    logic                          space;
    logic                          rd_go;
    logic                          end_cell;
    logic                          push;
    logic [DATA_W:0]               entry;
    logic [1:0]                    cnt;
    logic [BYTE_W-1:0]             b;

    always_comb begin
        s_d      = s_q;
        mis      = 1'b0;
        cell_in  = '0;
        cell_out = '0;
        waddr    = '0;
        wr_next  = '0;
        word     = din;
        store    = 1'b0;
        raddr    = '0;
        rd_next  = '0;
        end_cell = 1'b0;
        push     = 1'b0;
        entry    = '0;
        b        = din[BYTE_W-1:0];

        // queue geometry from the configuration
        if (5'(s_q.ql2) + s_q.ql1 >= 5'(TOTAL_BLOCKS)) begin
            ql3_len = 4'h0;
        end else begin
            ql3_len = 4'(5'(TOTAL_BLOCKS) - s_q.ql1 - 5'(s_q.ql2));
        end
        depth[0] = (AW+1)'(s_q.ql1) << BSH; // R6
        depth[1] = (AW+1)'(s_q.ql2) << BSH; // R6
        depth[2] = (AW+1)'(ql3_len) << BSH; // R6
        base[0]  = '0;
        base[1]  = AW'(depth[0]);
        base[2]  = AW'(depth[0] + depth[1]);
        last_idx = s_q.cell_word_count - 6'h01; // R7
        for (int i = 0; i < NUM_QUEUES; i++) begin
            max_cells[i] = depth[i] / (AW+1)'(s_q.cell_word_count); // R22
            wr_sof[i]    = s_q.wr_idx[i] == 6'h00 && !s_q.wr_phase[i];
            attempt[i]   = s_q.grant[1] && queue_write_enable[i]
                           && cell_discard_n;
            if (attempt[i] && (wr_sof[i] != in_cell_start)) begin
                mis = 1'b1; // R10
            end
        end

        // write side
        for (int i = 0; i < NUM_QUEUES; i++) begin
            waddr = base[i] + s_q.wr_ptr[i];
            if ({1'b0, s_q.wr_ptr[i]} + 1'b1 == depth[i]) begin
                wr_next = '0;
            end else begin
                wr_next = s_q.wr_ptr[i] + 1'b1;
            end
            store = 1'b0;
            word  = din;
            if (queue_write_enable[i] && !cell_discard_n) begin
                s_d.wr_ptr[i]   = s_q.abort_ptr[i]; // R12
                s_d.wr_idx[i]   = 6'h00;
                s_d.wr_phase[i] = 1'b0;
            end else if (attempt[i] && !mis && s_q.queue_full_n[i]) begin
                if (!s_q.port_ctl[PORT_IN_BYTE]) begin // R1
                    store = 1'b1; // R8
                end else if (!s_q.wr_phase[i]) begin
                    if (s_q.port_ctl[PORT_IN_STUFF]
                            && s_q.wr_idx[i] == last_idx) begin
                        word  = {b, b}; // R3
                        store = 1'b1;
                    end else begin
                        s_d.wr_byte[i]  = b;
                        s_d.wr_phase[i] = 1'b1;
                    end
                end else begin
                    if (s_q.port_ctl[PORT_IN_BIG]) begin
                        word = {s_q.wr_byte[i], b}; // R2
                    end else begin
                        word = {b, s_q.wr_byte[i]}; // R2
                    end
                    s_d.wr_phase[i] = 1'b0;
                    store           = 1'b1;
                end
                if (store) begin
                    s_d.mem[waddr] = word; // R8
                    s_d.wr_ptr[i]  = wr_next;
                    if (s_q.wr_idx[i] == last_idx) begin
                        cell_in[i]       = 1'b1; // R11
                        s_d.wr_idx[i]    = 6'h00;
                        s_d.abort_ptr[i] = wr_next; // R11
                    end else begin
                        s_d.wr_idx[i] = s_q.wr_idx[i] + 6'h01;
                    end
                end
            end
        end
        if (mis) begin
            s_d.misalign_n = 1'b0; // R10
        end else if (|attempt) begin
            s_d.misalign_n = 1'b1;
        end

        // read side
        if (queue_select == SEL_QUEUE_THREE) begin
            sel = 2'h2; // R14
        end else if (queue_select == SEL_QUEUE_TWO) begin
            sel = 2'h1; // R14
        end else begin
            sel = 2'h0; // R14
        end
        space = s_q.obuf_cnt != OBUF_FULL || out_word_ready;
        rd_go = out_read_enable && s_q.cell_available[sel] && space; // R13
        raddr = base[sel] + s_q.rd_ptr[sel];
        if ({1'b0, s_q.rd_ptr[sel]} + 1'b1 == depth[sel]) begin
            rd_next = '0;
        end else begin
            rd_next = s_q.rd_ptr[sel] + 1'b1;
        end
        if (rd_go) begin
            if (!s_q.port_ctl[PORT_OUT_BYTE] || !s_q.rd_phase[sel]) begin
                s_d.hold[sel]     = s_q.mem[raddr];
                s_d.hold_sof[sel] = s_q.rd_idx[sel] == 6'h00; // R17
                s_d.rd_ptr[sel]   = rd_next;
                if (!s_q.port_ctl[PORT_OUT_BYTE]) begin // R4
                    end_cell = s_q.rd_idx[sel] == last_idx;
                end else if (s_q.port_ctl[PORT_OUT_DESTUFF]
                        && s_q.rd_idx[sel] == last_idx) begin
                    end_cell = 1'b1; // R5
                end else begin
                    s_d.rd_phase[sel] = 1'b1;
                end
            end else begin
                s_d.hold[sel] = {s_q.hold[sel][BYTE_W-1:0],
                                 s_q.hold[sel][DATA_W-1:BYTE_W]}; // R15
                s_d.hold_sof[sel] = 1'b0; // R17
                s_d.rd_phase[sel] = 1'b0;
                end_cell          = s_q.rd_idx[sel] == last_idx;
            end
            if (end_cell) begin
                s_d.rd_idx[sel] = 6'h00;
                cell_out[sel]   = 1'b1; // R16
            end else if (!s_q.port_ctl[PORT_OUT_BYTE]
                    || s_q.rd_phase[sel]) begin
                s_d.rd_idx[sel] = s_q.rd_idx[sel] + 6'h01;
            end
            push  = 1'b1;
            entry = {s_d.hold_sof[sel], s_d.hold[sel]};
        end else if (sel != s_q.sel_q && space) begin
            push  = 1'b1; // R18
            entry = {s_q.hold_sof[sel], s_q.hold[sel]};
        end
        s_d.sel_q = sel;

        // flags per queue
        for (int i = 0; i < NUM_QUEUES; i++) begin
            cells_after[i] = s_q.cells[i] + (AW+1)'(cell_in[i])
                             - (AW+1)'(cell_out[i]);
            s_d.cells[i]   = cells_after[i];
            s_d.ca_pipe[i] = {s_q.ca_pipe[i][0],
                              cell_in[i] && s_q.cells[i] == '0}; // R20
            s_d.cell_available[i] = (s_q.cell_available[i]
                                     | s_q.ca_pipe[i][1]) // R20
                                    & ~(cell_out[i]
                                        && cells_after[i] == '0); // R21
            s_d.fr_pipe[i] = {s_q.fr_pipe[i][0],
                              cell_out[i] && !s_q.queue_full_n[i]};
            if (cells_after[i] >= max_cells[i]) begin
                s_d.queue_full_n[i] = 1'b0; // R22
            end else begin
                s_d.queue_full_n[i] = s_q.queue_full_n[i]
                                      | s_q.fr_pipe[i][1]; // R22
            end
        end

        // two-entry output buffer, head drives the pins
        cnt = s_q.obuf_cnt;
        if (out_word_ready && cnt != 2'h0) begin
            s_d.obuf[0] = s_q.obuf[1];
            cnt         = cnt - 2'h1;
        end
        if (push) begin
            if (cnt == 2'h0) begin
                s_d.obuf[0] = entry;
            end else begin
                s_d.obuf[1] = entry;
            end
            cnt = cnt + 2'h1;
        end
        if (cnt == 2'h0) begin
            s_d.obuf[0] = '0; // R17
        end
        s_d.obuf_cnt  = cnt;
        s_d.out_valid = cnt != 2'h0;

        // input port hand-over
        s_d.grant = {s_q.grant[0], config_bus_request_n}; // R24

        // configuration port, live only while the input is handed over
        if (!s_q.grant[1]) begin
            if (prog_write && s_q.prog_widx != PROG_REG_COUNT) begin
                case (s_q.prog_widx)
                    PROG_IDX_PORT: begin
                        s_d.port_ctl = prog_wdata[4:0];
                    end
                    PROG_IDX_QL1: begin
                        if (prog_wdata[4:0] > QL1_MAX) begin
                            s_d.ql1 = QL1_MAX;
                        end else begin
                            s_d.ql1 = prog_wdata[4:0];
                        end
                    end
                    PROG_IDX_QL2: begin
                        s_d.ql2 = prog_wdata[3:0];
                        if (prog_wdata[3:0] > QL2_MAX) begin
                            s_d.ql2 = QL2_MAX;
                        end
                    end
                    PROG_IDX_CELL_WORD_COUNT: begin
                        if (prog_wdata[5:0] < CELL_WORD_COUNT_MIN) begin
                            s_d.cell_word_count = CELL_WORD_COUNT_MIN;
                        end else if (prog_wdata[5:0] > CELL_WORD_COUNT_MAX) begin
                            s_d.cell_word_count = CELL_WORD_COUNT_MAX;
                        end else begin
                            s_d.cell_word_count = prog_wdata[5:0];
                        end
                    end
                    default: begin
                        s_d.prog_widx = s_q.prog_widx + 4'h1;
                    end
                endcase
                s_d.prog_widx = s_q.prog_widx + 4'h1;
            end
            if (prog_read) begin
                case (s_q.prog_ridx)
                    PROG_IDX_PORT: s_d.prog_rdata = 8'(s_q.port_ctl);
                    PROG_IDX_QL1:  s_d.prog_rdata = 8'(s_q.ql1);
                    PROG_IDX_QL2:  s_d.prog_rdata = 8'(s_q.ql2);
                    PROG_IDX_CELL_WORD_COUNT: s_d.prog_rdata = 8'(s_q.cell_word_count);
                    default:       s_d.prog_rdata = 8'h00;
                endcase
                if (s_q.prog_ridx == PROG_IDX_LAST) begin
                    s_d.prog_ridx = 4'h0;
                end else begin
                    s_d.prog_ridx = s_q.prog_ridx + 4'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_q              <= '0;
            s_q.queue_full_n <= '1;
            s_q.misalign_n   <= 1'b1;
            s_q.grant        <= 2'h3;
            s_q.port_ctl     <= PORT_RST;
            s_q.ql1          <= QL1_RST;
            s_q.ql2          <= QL2_RST;
            s_q.cell_word_count         <= CELL_WORD_COUNT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign queue_full_n       = s_q.queue_full_n;
    assign cell_misalign_n    = s_q.misalign_n;
    assign input_port_granted = s_q.grant[1];
    assign prog_rdata         = s_q.prog_rdata;
    assign cell_available     = s_q.cell_available;
    assign q_data             = s_q.obuf[0][DATA_W-1:0];
    assign out_cell_start     = s_q.obuf[0][DATA_W];
    assign out_word_valid     = s_q.out_valid;

endmodule

//--- bench/fifo_port_properties.sv
/* cell fifo port checker.
   assumes one clock, sync active-high reset. */
module fifo_port_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // write side
    input wire logic [2:0]  queue_write_enable,
    input wire logic [2:0]  queue_full_n,
    input wire logic        cell_misalign_n,
    input wire logic        input_port_granted,
    input wire logic        config_bus_request_n,
    // read side
    input wire logic        out_read_enable,
    input wire logic [2:0]  cell_available,
    input wire logic [17:0] q_data,
    input wire logic        out_cell_start,
    input wire logic        out_word_valid,
    input wire logic        out_word_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    reset_state_a: assert property (disable iff (1'b0) sys_rst |=>
        cell_available == 3'h0 && queue_full_n == 3'h7 && cell_misalign_n
        && !out_cell_start && !out_word_valid) else $error("bad reset state");
    grant_drop_a: assert property (
        !config_bus_request_n ##1 !config_bus_request_n
        |-> ##[1:2] !input_port_granted) else $error("grant held");
    grant_back_a: assert property (
        config_bus_request_n ##1 config_bus_request_n
        |-> ##[1:2] input_port_granted) else $error("no grant");
    avail_rise_a: assert property (
        $rose(cell_available[0]) |-> $past(queue_write_enable[0], 3))
        else $error("early cell flag");
    avail_drop_a: assert property (
        $fell(cell_available[0]) |-> $past(out_read_enable))
        else $error("cell flag lost");
    misalign_set_a: assert property (
        $fell(cell_misalign_n) |-> $past(queue_write_enable) != 3'h0)
        else $error("stray misalign");
    misalign_hold_a: assert property (
        !cell_misalign_n && queue_write_enable == 3'h0 |=> !cell_misalign_n)
        else $error("misalign lost");
    full_set_a: assert property (
        $fell(queue_full_n[2]) |-> $past(queue_write_enable[2]))
        else $error("stray full");
    full_clear_a: assert property (
        $rose(queue_full_n[2]) |-> $past(out_read_enable, 3))
        else $error("early release");
    head_hold_a: assert property (
        out_word_valid && !out_word_ready |=> out_word_valid
        && $stable(q_data) && $stable(out_cell_start))
        else $error("head moved");
    start_valid_a: assert property (
        out_cell_start |-> out_word_valid) else $error("stray start");
endmodule

//--- bench/word_sink_model.sv
/* reader model: pops and keeps output words, stalls on request.
   assumes the fifo's clk and sys_rst. */
module word_sink_model (
    // clock and reset
    input wire logic        clk,
    input wire logic        sys_rst,
    // output buffer
    input wire logic        out_word_valid,
    input wire logic [17:0] q_data,
    input wire logic        out_cell_start,
    output logic            out_word_ready,
    // control
    input wire logic        stall_en
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [18:0] got[$];
    logic [1:0]  phase_q = 2'h0;

    always @(posedge clk) begin
        if (!sys_rst && out_word_valid && out_word_ready)
            got.push_back({out_cell_start, q_data});
        phase_q <= phase_q + 2'h1;
        // stall half the time to fill the buffer
        out_word_ready <= !stall_en || phase_q[1];
    end
endmodule

//--- bench/testbench.sv
/* cell fifo bench: program, move cells, fill a queue.
   assumes the fifo, package and models. */
module testbench
    import multi_queue_cell_fifo_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [5:0] CS = 6'h0a;
    localparam int         N_CELLS = (TOTAL_BLOCKS - 13) * 32 / 10;
    logic                  clk = 1'b0;
    logic                  sys_rst = 1'b1;
    logic [DATA_W-1:0]     din = 18'h00000;
    logic [NUM_QUEUES-1:0] wen = 3'h0;
    logic                  in_cell_start = 1'b0;
    logic                  cell_discard_n = 1'b1;
    logic                  config_bus_request_n = 1'b1;
    logic                  prog_write = 1'b0;
    logic                  prog_read = 1'b0;
    logic [7:0]            prog_wdata = 8'h00;
    logic [1:0]            queue_select = 2'h0;
    logic                  out_read_enable = 1'b0;
    logic                  stall_en = 1'b0;
    logic [NUM_QUEUES-1:0] queue_full_n, cell_available;
    logic                  cell_misalign_n, input_port_granted;
    logic                  out_cell_start, out_word_valid, out_word_ready;
    logic [7:0]            prog_rdata;
    logic [DATA_W-1:0]     q_data;
    logic [DATA_W-1:0]     expq[$];
    logic [4:0]            port;
    int                    n_mismatch = 0;
    int                    total_checks = 0;

    always #4 clk = ~clk;

    multi_queue_cell_fifo #(.BLOCK_WORDS(32)) dut_u (
        .clk, .sys_rst, .din, .queue_write_enable(wen), .in_cell_start,
        .cell_discard_n, .queue_full_n, .cell_misalign_n,
        .input_port_granted, .config_bus_request_n, .prog_write,
        .prog_wdata, .prog_read, .prog_rdata, .queue_select,
        .out_read_enable, .cell_available, .q_data, .out_cell_start,
        .out_word_valid, .out_word_ready);
    word_sink_model sink_u (.clk, .sys_rst, .out_word_valid, .q_data,
        .out_cell_start, .out_word_ready, .stall_en);

    task automatic check(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [17:0] val(input int k, input int s);
        return 18'(k * 1031 + s * 77 + 5);
    endfunction

    task automatic do_reset;
        sys_rst <= 1'b1;
        tick(4);
        sys_rst <= 1'b0;
    endtask

    task automatic set_grant(input logic req_n);
        config_bus_request_n <= req_n;
        for (int i = 0; i < 8 && input_port_granted !== req_n; i++)
            @(posedge clk);
        check(input_port_granted, req_n);
    endtask

    task automatic prog(input logic wr, input logic [7:0] d);
        prog_write <= wr;
        prog_read <= !wr;
        prog_wdata <= d;
        @(posedge clk);
        prog_write <= 1'b0;
        prog_read <= 1'b0;
        @(posedge clk);
    endtask

    task automatic configure;
        logic [7:0] dflt[4] = '{8'h00, 8'h08, 8'h06, 8'h1b};
        logic [7:0] vset[4] = '{{3'h0, port}, 8'h07, 8'h06, {2'h0, CS}};
        set_grant(1'b0);
        for (int i = 0; i < 14; i++) begin
            if (i == 4)
                for (int j = 0; j < 11; j++)
                    prog(1'b1, j < 4 ? vset[j] : 8'hff);
            prog(1'b0, 8'h00);
            check(prog_rdata, i < 4 ? dflt[i]
                  : i < 10 ? 8'h00 : vset[i - 10]);
        end
        set_grant(1'b1);
    endtask

    task automatic build_exp(input int s);
        logic [17:0] a, b, w;
        expq.delete();
        for (int j = 0; j < CS; j++) begin
            a = val(2 * j, s);
            b = (port[2] && j == CS - 1) ? a : val(2 * j + 1, s);
            w = !port[0] ? val(j, s) : port[1] ? {a[8:0], b[8:0]}
                : {b[8:0], a[8:0]};
            expq.push_back(w);
            if (port[3] && !(port[4] && j == CS - 1))
                expq.push_back({w[8:0], w[17:9]});
        end
    endtask

    task automatic write_cell(input logic [2:0] en, input int s,
                              input bit chk, input int cut);
        int n;
        logic [17:0] u;
        n = cut > 0 ? cut : !port[0] ? CS : port[2] ? 2 * CS - 1 : 2 * CS;
        for (int k = 0; k < n; k++) begin
            u = val(k, s);
            din <= port[0] ? {~u[8:0], u[8:0]} : u;
            in_cell_start <= k == 0;
            wen <= en;
            @(posedge clk);
        end
        wen <= 3'h0;
        in_cell_start <= 1'b0;
        if (chk) begin
            tick(2);
            check(cell_available & en, 3'h0);
            tick(1);
            check(cell_available & en, en);
        end
    endtask

    task automatic read_cell(input logic [1:0] sel, input int n,
                             input bit stall);
        sink_u.got.delete();
        stall_en <= stall;
        queue_select <= sel;
        out_read_enable <= 1'b1;
        for (int i = 0; i < 400 && (stall ? sink_u.got.size() < n : i < n);
             i++)
            @(posedge clk);
        out_read_enable <= 1'b0;
        tick(6);
        check(sink_u.got.size(), n);
        if (sink_u.got.size() == n)
            for (int i = 0; i < n; i++)
                check(sink_u.got[i], {i == 0, expq[i]});
    endtask

    initial begin
        static logic [4:0] cfgs[3] = '{5'h1f, 5'h09, 5'h00};
        int cnt;
        for (int c = 0; c < 3; c++) begin
            port = cfgs[c];
            do_reset();
            configure();
            build_exp(c);
            write_cell(3'h7, c, 1, 0);
            for (int q = 1; q < 4; q++)
                read_cell(2'(q), expq.size(), 1);
        end
        wen <= 3'h1;
        @(posedge clk);
        wen <= 3'h0;
        tick(1);
        check(cell_misalign_n, 1'b0);
        write_cell(3'h1, 6, 0, 4);
        tick(1);
        cell_discard_n <= 1'b0;
        wen <= 3'h1;
        @(posedge clk);
        cell_discard_n <= 1'b1;
        build_exp(7);
        write_cell(3'h1, 7, 1, 0);
        check(cell_misalign_n, 1'b1);
        read_cell(2'h0, CS, 1);
        cnt = 0;
        for (int q = 0; q < 20 && queue_full_n[2] !== 1'b0; q++) begin
            write_cell(3'h4, 20 + q, 0, 0);
            tick(2);
            cnt++;
        end
        check(cnt, N_CELLS);
        write_cell(3'h4, 50, 0, 0);
        for (int q = 0; q < N_CELLS; q++) begin
            build_exp(20 + q);
            read_cell(2'h3, CS, 0);
            if (q == 0)
                check(queue_full_n[2], 1'b1);
        end
        check(cell_available[2], 1'b0);
        test_done();
    end

    initial begin
        tick(60000);
        n_mismatch++;
        test_done();
    end
endmodule

bind multi_queue_cell_fifo fifo_port_checker chk_u (.clk, .sys_rst,
    .queue_write_enable, .queue_full_n, .cell_misalign_n,
    .input_port_granted, .config_bus_request_n, .out_read_enable,
    .cell_available, .q_data, .out_cell_start, .out_word_valid,
    .out_word_ready);
